// file: logic/sbpd_cfg.svh
// Constants for the shared bus phase decode block
// Behaviour
// - Command low: bus bits carry data bits
// - 16-bit command high: bits 15..12 byte enables
// - 16-bit command high: device ignores bits 11..8
// - Command high: bits 7..2 carry address 7..2
// - 8-bit mode: host holds bits 15..8 low
// - All logic runs from one reference clock
// - Bits 1..0 address in 8-bit, ignored 16-bit
// - Chip select low enables access, else ignored
// - Strap at reset: low 8-bit, high 16-bit
`ifndef SBPD_CFG_SVH
`define SBPD_CFG_SVH

// ****************************************
// Bus field positions
// ****************************************
`define SBPD_BUS_W 16
`define SBPD_BE_HI 15
`define SBPD_BE_LO 12
`define SBPD_ADDR_HI 7
`define SBPD_ADDR_LO 2
`define SBPD_BYTE_HI 7

// ****************************************
// Reset values
// ****************************************
`define SBPD_ADDR_RST 8'h00
`define SBPD_BE_RST 4'h0
`define SBPD_DATA_RST 16'h0000

// ****************************************
// Timing
// ****************************************
`define SBPD_CLK_NS 8
`define SBPD_STROBE_NS 64
`define SBPD_STROBE_CYC ((`SBPD_STROBE_NS) / (`SBPD_CLK_NS))
`define SBPD_CNT_W 4

`endif

// file: logic/sbpd_pkg.sv
// Types for the shared bus phase decode block
package sbpd_pkg;

  // Host sequencer, Gray coded along the transfer path
  typedef enum logic [2:0] {
    SBPD_IDLE = 3'h0,
    SBPD_A_SETUP = 3'h1,
    SBPD_A_STROBE = 3'h3,
    SBPD_A_HOLD = 3'h2,
    SBPD_D_SETUP = 3'h6,
    SBPD_D_STROBE = 3'h7,
    SBPD_D_HOLD = 3'h5,
    SBPD_DONE = 3'h4
  } sbpd_state_t;

endpackage

// file: logic/sbpd_if.sv
// Shared bus pins between host and device
`timescale 1ns/10ps
interface sbpd_if;
  logic chip_select_n;
  logic cmd_type;
  logic rd_n;
  logic wr_n;
  logic bus_width_strap;
  logic [15:0] host_bus_out;
  logic host_bus_oe;
  logic [15:0] dev_bus_out;
  logic dev_bus_oe;
  logic [15:0] shared_bus;

  // Wire level, pulled down when nobody drives
  assign shared_bus = host_bus_oe ? host_bus_out :
                      dev_bus_oe ? dev_bus_out : 16'h0000;

  modport dev (
    input chip_select_n,
    input cmd_type,
    input rd_n,
    input wr_n,
    input bus_width_strap,
    input shared_bus,
    output dev_bus_out,
    output dev_bus_oe
  );

  modport host (
    output chip_select_n,
    output cmd_type,
    output rd_n,
    output wr_n,
    output host_bus_out,
    output host_bus_oe,
    input shared_bus
  );
endinterface

// file: logic/sbpd_device.sv
// Device end: decodes bus phases into address, enables and data
`timescale 1ns/10ps
`include "sbpd_cfg.svh"
module sbpd_device (
  input wire logic clk,
  input wire logic rst,
  sbpd_if.dev bus,
  output logic width_16,
  output logic [7:0] addr,
  output logic [3:0] byte_lane_enable,
  output logic [15:0] wr_data,
  output logic wr_valid,
  output logic rd_req,
  input wire logic [15:0] rd_data
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [19:0] sync1;
  logic [19:0] sync2;
  logic rd_n_d;
  logic wr_n_d;
  logic strap_pending;

  // All state below runs on the one clock
  always_ff @(posedge clk) begin
    sync1 <= {bus.chip_select_n, bus.cmd_type, bus.rd_n, bus.wr_n,
              bus.shared_bus};
    sync2 <= sync1;
  end

  wire cs_n_s = sync2[19];
  wire cmd_s = sync2[18];
  wire rd_n_s = sync2[17];
  wire wr_n_s = sync2[16];
  wire [15:0] sd_s = sync2[15:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_n_d <= 1'b1;
      wr_n_d <= 1'b1;
    end else begin
      rd_n_d <= rd_n_s;
      wr_n_d <= wr_n_s;
    end
  end

  wire sel = !cs_n_s;
  wire wr_evt = sel && !wr_n_s && wr_n_d;
  wire rd_evt = sel && !rd_n_s && rd_n_d;

  // ****************************************
  // Bus width strap
  // ****************************************
  logic strap1;
  logic strap2;
  always_ff @(posedge clk) begin
    strap1 <= bus.bus_width_strap;
    strap2 <= strap1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      strap_pending <= 1'b1;
      width_16 <= 1'b1;
    end else if (strap_pending) begin
      strap_pending <= 1'b0;
      width_16 <= strap2;
    end
  end

  // ****************************************
  // Address phase
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      addr <= `SBPD_ADDR_RST;
      byte_lane_enable <= `SBPD_BE_RST;
    end else if (wr_evt && cmd_s) begin
      if (width_16) begin
        // Bits 11..8 and 1..0 are not looked at
        addr <= {sd_s[`SBPD_ADDR_HI:`SBPD_ADDR_LO], 2'b00};
        byte_lane_enable <= sd_s[`SBPD_BE_HI:`SBPD_BE_LO];
      end else begin
        addr <= sd_s[`SBPD_BYTE_HI:0];
        byte_lane_enable <= 4'h1 << sd_s[1:0];
      end
    end
  end

  // ****************************************
  // Data phase
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_data <= `SBPD_DATA_RST;
      wr_valid <= 1'b0;
      rd_req <= 1'b0;
    end else begin
      wr_valid <= wr_evt && !cmd_s;
      rd_req <= rd_evt && !cmd_s;
      if (wr_evt && !cmd_s) begin
        if (width_16) begin
          wr_data <= sd_s;
        end else begin
          wr_data <= {8'h00, sd_s[`SBPD_BYTE_HI:0]};
        end
      end
    end
  end

  // Read data driven for as long as the read strobe, three clocks behind it
  always_ff @(posedge clk) begin
    if (rst) begin
      bus.dev_bus_oe <= 1'b0;
      bus.dev_bus_out <= `SBPD_DATA_RST;
    end else begin
      bus.dev_bus_oe <= sel && !cmd_s && !rd_n_s;
      if (width_16) begin
        bus.dev_bus_out <= rd_data;
      end else begin
        bus.dev_bus_out <= {8'h00, rd_data[`SBPD_BYTE_HI:0]};
      end
    end
  end

endmodule

// file: logic/sbpd_host.sv
// Host end: sequences address and data phases on the shared bus
`timescale 1ns/10ps
`include "sbpd_cfg.svh"
module sbpd_host (
  input wire logic clk,
  input wire logic rst,
  sbpd_if.host bus,
  input wire logic width_16,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [3:0] req_be,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata
);

  // ****************************************
  // Sequencer
  // ****************************************
  sbpd_pkg::sbpd_state_t state;
  logic [`SBPD_CNT_W-1:0] cnt;
  logic is_write;
  logic [15:0] addr_word;
  logic [15:0] data_word;
  logic [15:0] sd1;
  logic [15:0] sd2;

  localparam logic [`SBPD_CNT_W-1:0] STROBE_LAST =
    `SBPD_CNT_W'(`SBPD_STROBE_CYC - 1);

  always_ff @(posedge clk) begin
    sd1 <= bus.shared_bus;
    sd2 <= sd1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= sbpd_pkg::SBPD_IDLE;
      cnt <= '0;
      is_write <= 1'b0;
      addr_word <= 16'h0000;
      data_word <= 16'h0000;
    end else begin
      case (state)
        sbpd_pkg::SBPD_IDLE: begin
          if (req_valid) begin
            is_write <= req_write;
            if (width_16) begin
              // Enables high, 11..8 and 1..0 held low
              addr_word <= {req_be, 4'h0, req_addr[7:2], 2'b00};
              data_word <= req_wdata;
            end else begin
              addr_word <= {8'h00, req_addr};
              data_word <= {8'h00, req_wdata[7:0]};
            end
            state <= sbpd_pkg::SBPD_A_SETUP;
          end
        end
        sbpd_pkg::SBPD_A_SETUP: begin
          cnt <= '0;
          state <= sbpd_pkg::SBPD_A_STROBE;
        end
        sbpd_pkg::SBPD_A_STROBE: begin
          cnt <= cnt + 1'b1;
          if (cnt == STROBE_LAST) begin
            state <= sbpd_pkg::SBPD_A_HOLD;
          end
        end
        sbpd_pkg::SBPD_A_HOLD: begin
          state <= sbpd_pkg::SBPD_D_SETUP;
        end
        sbpd_pkg::SBPD_D_SETUP: begin
          cnt <= '0;
          state <= sbpd_pkg::SBPD_D_STROBE;
        end
        sbpd_pkg::SBPD_D_STROBE: begin
          cnt <= cnt + 1'b1;
          if (cnt == STROBE_LAST) begin
            state <= sbpd_pkg::SBPD_D_HOLD;
          end
        end
        sbpd_pkg::SBPD_D_HOLD: begin
          state <= sbpd_pkg::SBPD_DONE;
        end
        default: begin
          state <= sbpd_pkg::SBPD_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  wire in_addr = state == sbpd_pkg::SBPD_A_SETUP ||
                 state == sbpd_pkg::SBPD_A_STROBE ||
                 state == sbpd_pkg::SBPD_A_HOLD;
  wire in_data = state == sbpd_pkg::SBPD_D_SETUP ||
                 state == sbpd_pkg::SBPD_D_STROBE ||
                 state == sbpd_pkg::SBPD_D_HOLD;
  wire strobe = state == sbpd_pkg::SBPD_A_STROBE ||
                state == sbpd_pkg::SBPD_D_STROBE;

  always_ff @(posedge clk) begin
    if (rst) begin
      bus.chip_select_n <= 1'b1;
      bus.cmd_type <= 1'b0;
      bus.wr_n <= 1'b1;
      bus.rd_n <= 1'b1;
      bus.host_bus_oe <= 1'b0;
      bus.host_bus_out <= 16'h0000;
    end else begin
      bus.chip_select_n <= !(in_addr || in_data);
      bus.cmd_type <= in_addr;
      bus.wr_n <= !(strobe && (in_addr || is_write));
      bus.rd_n <= !(strobe && in_data && !is_write);
      bus.host_bus_oe <= in_addr || (in_data && is_write);
      bus.host_bus_out <= in_addr ? addr_word : data_word;
    end
  end

  // ****************************************
  // User side
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      req_ready <= state == sbpd_pkg::SBPD_DONE;
      rsp_valid <= state == sbpd_pkg::SBPD_DONE && !is_write;
      if (state == sbpd_pkg::SBPD_D_STROBE && cnt == STROBE_LAST) begin
        rsp_rdata <= width_16 ? sd2 : {8'h00, sd2[7:0]};
      end
    end
  end

endmodule

// file: bench/sbpd_monitor.sv
// Checker on the shared bus pins
`timescale 1ns/10ps
module sbpd_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic cmd_type,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic bus_width_strap,
  input wire logic [15:0] host_bus_out,
  input wire logic host_bus_oe,
  input wire logic [15:0] dev_bus_out,
  input wire logic dev_bus_oe,
  input wire logic [15:0] shared_bus
);
  // ********************
  // Pin checks
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  one_driver_a: assert property (
    !(host_bus_oe && dev_bus_oe)) else $error("both ends drive");
  addr_fields_a: assert property (
    host_bus_oe && cmd_type && bus_width_strap |->
    host_bus_out[11:8] == 4'h0 && host_bus_out[1:0] == 2'h0)
    else $error("bad address phase fields");
  host_upper_a: assert property (
    host_bus_oe && !bus_width_strap |-> host_bus_out[15:8] == 8'h00)
    else $error("host drives upper byte");
  dev_upper_a: assert property (
    dev_bus_oe && !bus_width_strap |-> dev_bus_out[15:8] == 8'h00)
    else $error("device drives upper byte");
  strobe_select_a: assert property (
    !(wr_n && rd_n) |-> !chip_select_n) else $error("strobe unselected");
  read_phase_a: assert property (
    !rd_n |-> !cmd_type && !host_bus_oe) else $error("bad read phase");
  dev_oe_read_a: assert property (
    $rose(dev_bus_oe) |-> !rd_n && $past(!rd_n, 2) && !chip_select_n)
    else $error("device drives outside a read");
  bus_hold_a: assert property (
    !wr_n && $past(!wr_n) |-> $stable(shared_bus) && $stable(cmd_type))
    else $error("bus moved under strobe");
  strobe_len_a: assert property (
    $fell(wr_n) |-> !wr_n [*8] ##1 wr_n) else $error("strobe length");
endmodule

// file: bench/tb.sv
// Bench for host and device ends joined by the bus
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [3:0] be;
    logic [15:0] d;
    logic [7:0] ea;
    logic [3:0] ebe;
    logic [15:0] ed;
  } sbpd_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [3:0] req_be = 4'h0;
  logic [15:0] req_wdata = 16'h0000;
  logic [15:0] rd_data = 16'h0000;
  logic req_ready, rsp_valid, width_16, wr_valid, rd_req;
  logic [7:0] addr;
  logic [3:0] byte_lane_enable;
  logic [15:0] rsp_rdata, wr_data;
  int miscompares = 0;
  int n_checks = 0;
  int nw = 0;
  int nr = 0;
  sbpd_row_t rows [4] = '{
    '{1'b1, 8'h37, 4'hf, 16'ha5c3, 8'h34, 4'hf, 16'ha5c3},
    '{1'b0, 8'hfe, 4'h3, 16'h1e2d, 8'hfc, 4'h3, 16'h1e2d},
    '{1'b1, 8'h09, 4'h1, 16'hffff, 8'h08, 4'h1, 16'hffff},
    '{1'b0, 8'h42, 4'hc, 16'h8001, 8'h40, 4'hc, 16'h8001}};

  // ********************
  // Ends and checker
  // ********************
  sbpd_if i_sbpd_if ();
  assign i_sbpd_if.bus_width_strap = strap;
  sbpd_host i_sbpd_host (.clk(clk), .rst(rst), .bus(i_sbpd_if.host),
    .width_16(width_16), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  sbpd_device i_sbpd_device (.clk(clk), .rst(rst), .bus(i_sbpd_if.dev),
    .width_16(width_16), .addr(addr), .byte_lane_enable(byte_lane_enable),
    .wr_data(wr_data), .wr_valid(wr_valid), .rd_req(rd_req),
    .rd_data(rd_data));
  sbpd_monitor i_sbpd_monitor (.clk(clk), .rst(rst),
    .chip_select_n(i_sbpd_if.chip_select_n), .cmd_type(i_sbpd_if.cmd_type),
    .rd_n(i_sbpd_if.rd_n), .wr_n(i_sbpd_if.wr_n),
    .bus_width_strap(i_sbpd_if.bus_width_strap),
    .host_bus_out(i_sbpd_if.host_bus_out),
    .host_bus_oe(i_sbpd_if.host_bus_oe),
    .dev_bus_out(i_sbpd_if.dev_bus_out), .dev_bus_oe(i_sbpd_if.dev_bus_oe),
    .shared_bus(i_sbpd_if.shared_bus));

  always @(posedge clk) begin
    if (wr_valid === 1'b1) nw <= nw + 1;
    if (rd_req === 1'b1) nr <= nr + 1;
  end

  // ********************
  // Tasks
  // ********************
  task automatic chk(input string s, input logic [15:0] e,
    input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic xfer(input sbpd_row_t r);
    int n0;
    n0 = r.w ? nw : nr;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= r.w;
    req_addr <= r.a;
    req_be <= r.be;
    req_wdata <= r.d;
    rd_data <= r.d;
    @(posedge clk);
    req_valid <= 1'b0;
    for (int i = 0; i < 40 && req_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (req_ready !== 1'b1) begin
      miscompares++;
      summarize();
    end
    chk("addr", 16'(r.ea), 16'(addr));
    chk("be", 16'(r.ebe), 16'(byte_lane_enable));
    chk("pulses", 16'(n0 + 1), 16'(r.w ? nw : nr));
    chk("data", r.ed, r.w ? wr_data : rsp_rdata);
    chk("rsp_valid", 16'(!r.w), 16'(rsp_valid));
  endtask

  // ********************
  // Sequence
  // ********************
  initial begin
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    chk("addr rst", 16'h0000, 16'(addr));
    chk("wr_data rst", 16'h0000, wr_data);
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("width", 16'h0001, 16'(width_16));
    foreach (rows[k]) xfer(rows[k]);
    @(posedge clk);
    strap <= 1'b0;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("width", 16'h0000, 16'(width_16));
    xfer('{1'b1, 8'hcb, 4'h0, 16'h5a3c, 8'hcb, 4'h8, 16'h003c});
    xfer('{1'b0, 8'h02, 4'hf, 16'hff81, 8'h02, 4'h4, 16'h0081});
    summarize();
  end
endmodule
